// [hw/ott_pkg.sv]
// Purpose: shared constants and types of the over-level trip timer
// Assumes: tick is a one-cycle pulse once per program cycle
// Notes:   levels are unsigned Q8.8 ratios to the pick-up threshold
package ott_pkg;
  // program cycle and setting steps, in milliseconds
  localparam int TICK_MS     = 5;
  localparam int DT_STEP_MS  = 5;
  localparam int K_STEP_MS   = 10;
  localparam int REL_STEP_MS = 5;
  localparam int DT_TICKS_PER_STEP  = DT_STEP_MS / TICK_MS;
  localparam int K_TICKS_PER_STEP   = K_STEP_MS / TICK_MS;
  localparam int REL_TICKS_PER_STEP = REL_STEP_MS / TICK_MS;
  localparam int REMAIN_MAX_S = 1800;
  localparam logic [18:0] REMAIN_MAX_TICKS =
    19'(REMAIN_MAX_S * 1000 / TICK_MS);
  // ratio arithmetic
  localparam logic [15:0] ONE_Q      = 16'h0100;
  localparam logic [15:0] RELEASE_Q  = 16'h00F9;
  localparam logic [11:0] EXP_UNIT   = 12'h064;
  localparam logic [39:0] FRAC_MUL   = 40'h0000000029;
  localparam int          FRAC_SHIFT = 12;
  // setting codes
  localparam logic [1:0] DLY_FIXED   = 2'h1;
  localparam logic [1:0] DLY_INVERSE = 2'h2;
  localparam logic [1:0] OPT_NO      = 2'h1;
  localparam logic [1:0] OPT_YES     = 2'h2;
  // values after reset
  localparam logic [17:0] RST_DT  = 18'h00008;
  localparam logic [12:0] RST_K   = 13'h0005;
  localparam logic [11:0] RST_EXP = 12'h064;
  localparam logic [14:0] RST_REL = 15'h000C;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_DT     = 8'h04;
  localparam logic [7:0] REG_DIAL   = 8'h08;
  localparam logic [7:0] REG_EXP    = 8'h0C;
  localparam logic [7:0] REG_REL    = 8'h10;
  localparam logic [7:0] REG_STAT   = 8'h14;
  localparam logic [7:0] REG_REMAIN = 8'h18;
  localparam logic [7:0] REG_LOGSEL = 8'h1C;
  localparam logic [7:0] REG_LOG0   = 8'h20;
  localparam logic [7:0] REG_LOG1   = 8'h24;
  localparam logic [7:0] REG_LOG2   = 8'h28;
  localparam logic [7:0] REG_LOG3   = 8'h2C;
  // events: pending bit order is start on/off, trip on/off, block on/off
  localparam int EV_PER_STAGE = 6;
  localparam int LOG_DEPTH    = 12;
  localparam logic [3:0] LOG_LAST = 4'hB;

  typedef enum logic [1:0] {TM_IDLE, TM_RUN, TM_REL, TM_TRIP} ott_tmr_type;
  typedef enum logic [1:0] {PW_LOAD, PW_MUL, PW_FRAC} ott_pw_type;

  typedef struct packed {
    logic [31:0] stamp;
    logic [4:0]  code;
    logic [2:0]  fault;
    logic [15:0] preTrig;
    logic [15:0] faultLvl;
    logic [15:0] preFault;
    logic [18:0] remain;
    logic [2:0]  group;
  } ott_log_type;

  typedef struct packed {
    ott_tmr_type tmr;
    ott_pw_type  pwSt;
    logic        start;
    logic        trip;
    logic        blocked;
    logic        pickup;
    logic [2:0]  blkSync;
    logic        blkLvl;
    logic [18:0] opCnt;
    logic [23:0] acc;
    logic [15:0] relCnt;
    logic [15:0] pw;
    logic [11:0] pwRem;
    logic [15:0] pwLat;
    logic [18:0] remain;
    logic [5:0]  evPend;
    logic        evValid;
    logic [4:0]  evCode;
    logic [31:0] evTime;
    logic [15:0] evLevel;
    logic        logWr;
    ott_log_type logEntry;
    logic [3:0]  logWp;
    logic [3:0]  logCnt;
    logic [3:0]  logSel;
    logic [1:0]  delayType;
    logic [1:0]  relMode;
    logic [1:0]  rstMode;
    logic [1:0]  contMode;
    logic        evOnEn;
    logic        evOffEn;
    logic [17:0] dtDelay;
    logic [12:0] dialK;
    logic [11:0] expo;
    logic [14:0] relDelay;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ott_state_type;

  localparam ott_state_type ST_RST = '{
    tmr: TM_IDLE, pwSt: PW_LOAD, pw: ONE_Q, pwLat: ONE_Q,
    delayType: DLY_FIXED, relMode: OPT_YES, rstMode: OPT_YES,
    contMode: OPT_NO, evOnEn: 1'b1, evOffEn: 1'b1,
    dtDelay: RST_DT, dialK: RST_K, expo: RST_EXP, relDelay: RST_REL,
    default: '0};
endpackage : ott_pkg

// [hw/ott_log_mem.sv]
// Purpose: fault record storage, one write port, registered read
// Assumes: addresses at or above DEPTH are never written
// Notes:   contents are not reset; only the read register is
`timescale 1ns/1ps
module ott_log_mem #(
  parameter int WIDTH = 110,
  parameter int DEPTH = 12,
  parameter int AW    = 4
) (
  // system
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // write side
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // read side
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdData <= '0;
    end else if (32'(rdAddr) < DEPTH) begin
      rdData <= mem[rdAddr];
    end else begin
      rdData <= '0;
    end
  end
endmodule : ott_log_mem

// [hw/ott_trip_timer.sv]
// Purpose: trip/release timing, events and fault record of one stage
// Assumes: levelRatio is measured level over threshold, Q8.8
// Notes:   all timing advances only on tick
// Behaviour
// - instant mode trips together with start
// - fixed delay trips when the operate count reaches the delay
// - inverse time is k over ratio-power minus one
// - delay type 1 fixed, 2 inverse, default fixed
// - fixed delay 5 ms steps, default 40 ms
// - zero fixed delay means instant stage
// - dial k 10 ms steps, default 50 ms
// - exponent 0.01 steps, default 1.00
// - release delay 5 ms steps, default 60 ms
// - delayed release holds start, else drops
// - counter clears after release or at loss
// - optional counting on through release time
// - default holds counter during release time
// - no trip during release without re-pick-up
// - events on every change, on/off selectable
// - four stages, six event codes each
// - events carry time stamp and process data
// - twelve-entry rolling log of on events
// - log entry fields as listed
// - start only unblocked, else blocked output
// - blocking clears start, release proceeds
// - pick-up above one, release below 97 percent
`timescale 1ns/1ps
module ott_trip_timer import ott_pkg::*; #(
  parameter int STAGE = 0
) (
  // system
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // measurement and context
  input  wire logic        tick,
  input  wire logic [15:0] levelRatio,
  input  wire logic [15:0] faultLevel,
  input  wire logic [15:0] preTrigLevel,
  input  wire logic [15:0] preFaultLevel,
  input  wire logic [2:0]  faultType,
  input  wire logic [2:0]  settingGroup,
  input  wire logic [31:0] timeStamp,
  input  wire logic        blockIn,
  // stage outputs
  output logic             start,
  output logic             trip,
  output logic             blocked,
  // event stream
  output logic             evValid,
  output logic      [4:0]  evCode,
  output logic      [31:0] evTime,
  output logic      [15:0] evLevel
);
  ott_state_type q;
  ott_state_type d;
  ott_log_type   logRd;
  logic          fixedMode;
  logic [18:0]   dtTicks;
  logic [23:0]   kTarget;
  logic [15:0]   relTicks;

  assign fixedMode = (q.delayType != DLY_INVERSE);
  assign dtTicks = 19'(32'(q.dtDelay) * DT_TICKS_PER_STEP);
  assign kTarget = 24'(32'(q.dialK) * K_TICKS_PER_STEP * 256);
  assign relTicks = 16'(32'(q.relDelay) * REL_TICKS_PER_STEP);

  ott_log_mem #(.WIDTH($bits(ott_log_type)), .DEPTH(LOG_DEPTH), .AW(4))
  uLog (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wrEn    (q.logWr),
    .wrAddr  (q.logWp),
    .wrData  (q.logEntry),
    .rdAddr  (q.logSel),
    .rdData  (logRd)
  );

  always_comb begin
    logic [31:0]  prod;
    logic [31:0]  p1;
    logic [39:0]  fr;
    logic [39:0]  sum;
    logic [15:0]  excess;
    logic [18:0]  nxtCnt;
    logic [24:0]  accSum;
    logic [23:0]  nxtAcc;
    logic [23:0]  accLeft;
    logic         reached;
    logic         pkNow;
    logic         act;
    logic [5:0]   newBits;
    logic [5:0]   clr;
    logic [2:0]   idx;
    logic [127:0] logWide;
    prod = 32'(q.pw) * 32'(levelRatio);
    p1 = 32'(q.pw) * 32'(levelRatio - ONE_Q);
    fr = ((40'(p1[31:8]) * 40'(q.pwRem) * FRAC_MUL) >> FRAC_SHIFT);
    sum = 40'(q.pw) + fr;
    excess = (q.pwLat > ONE_Q) ? q.pwLat - ONE_Q : 16'h0000;
    nxtCnt = (q.tmr == TM_IDLE) ? 19'h00000
           : (&q.opCnt) ? q.opCnt : q.opCnt + 19'h00001;
    accSum = 25'(q.acc) + 25'(excess);
    nxtAcc = (q.tmr == TM_IDLE) ? 24'h000000
           : accSum[24] ? 24'hFFFFFF : accSum[23:0];
    accLeft = (kTarget > nxtAcc) ? kTarget - nxtAcc : 24'h000000;
    reached = fixedMode ? (nxtCnt >= dtTicks) : (nxtAcc >= kTarget);
    // levels between 97 percent and one keep the previous pick-up
    pkNow = (levelRatio > ONE_Q) ? 1'b1
          : (levelRatio < RELEASE_Q) ? 1'b0 : q.pickup;
    act = pkNow & ~q.blkLvl;
    newBits = '0;
    clr = '0;
    idx = 3'h0;
    logWide = {18'h00000, logRd};
    d = q;

    // the second and third stages must agree before blocking changes
    d.blkSync = {q.blkSync[1:0], blockIn};
    if (q.blkSync[2] == q.blkSync[1]) begin
      d.blkLvl = q.blkSync[2];
    end

    // ratio power: integer steps by multiply, fraction by linear step
    unique case (q.pwSt)
      PW_LOAD: begin
        d.pw = ONE_Q;
        d.pwRem = q.expo;
        d.pwSt = PW_MUL;
      end
      PW_MUL: begin
        if (q.pwRem >= EXP_UNIT) begin
          d.pw = (|prod[31:24]) ? 16'hFFFF : prod[23:8];
          d.pwRem = q.pwRem - EXP_UNIT;
        end else begin
          d.pwSt = PW_FRAC;
        end
      end
      PW_FRAC: begin
        if (levelRatio > ONE_Q) begin
          d.pwLat = (|sum[39:16]) ? 16'hFFFF : sum[15:0];
        end else begin
          d.pwLat = q.pw;
        end
        d.pwSt = PW_LOAD;
      end
    endcase

    if (tick) begin
      d.pickup = pkNow;
      d.blocked = pkNow & q.blkLvl;
      unique case (q.tmr)
        TM_TRIP: begin
          if (!act) begin
            d.trip = 1'b0;
            d.start = 1'b0;
            d.opCnt = '0;
            d.acc = '0;
            d.tmr = TM_IDLE;
          end
        end
        TM_IDLE, TM_RUN, TM_REL: begin
          if (act) begin
            d.start = 1'b1;
            d.opCnt = nxtCnt;
            d.acc = nxtAcc;
            d.remain = fixedMode
              ? ((dtTicks > nxtCnt) ? dtTicks - nxtCnt : 19'h00000)
              : ((|accLeft[23:19]) ? REMAIN_MAX_TICKS
                 : 19'(accLeft[23:8]));
            if (d.remain > REMAIN_MAX_TICKS) begin
              d.remain = REMAIN_MAX_TICKS;
            end
            if (reached) begin
              d.trip = 1'b1;
              d.tmr = TM_TRIP;
            end else begin
              d.tmr = TM_RUN;
            end
          end else if (q.tmr == TM_RUN) begin
            // blocking drops start but timing goes on as a release
            d.start = ~q.blkLvl & (q.relMode == OPT_YES);
            d.relCnt = 16'h0001;
            if (q.rstMode == OPT_NO) begin
              d.opCnt = '0;
              d.acc = '0;
            end else if (q.contMode == OPT_YES) begin
              d.opCnt = nxtCnt;
              d.acc = nxtAcc;
            end
            if (16'h0001 >= relTicks) begin
              d.start = 1'b0;
              d.opCnt = '0;
              d.acc = '0;
              d.tmr = TM_IDLE;
            end else begin
              d.tmr = TM_REL;
            end
          end else if (q.tmr == TM_REL) begin
            d.start = q.start & ~q.blkLvl;
            d.relCnt = q.relCnt + 16'h0001;
            if (q.contMode == OPT_YES) begin
              d.opCnt = nxtCnt;
              d.acc = nxtAcc;
            end
            if (q.relCnt + 16'h0001 >= relTicks) begin
              d.start = 1'b0;
              d.opCnt = '0;
              d.acc = '0;
              d.tmr = TM_IDLE;
            end
          end
        end
      endcase
      newBits = {~d.blocked & q.blocked, d.blocked & ~q.blocked,
                 ~d.trip & q.trip, d.trip & ~q.trip,
                 ~d.start & q.start, d.start & ~q.start};
    end

    // one pending change leaves per cycle, lowest bit first
    for (int i = 5; i >= 0; i--) begin
      if (q.evPend[i]) begin
        idx = 3'(i);
      end
    end
    d.evValid = 1'b0;
    d.logWr = 1'b0;
    if (q.evPend != 6'h00) begin
      clr = 6'(6'h01 << idx);
      d.evValid = idx[0] ? q.evOffEn : q.evOnEn;
      d.evCode = 5'(STAGE * EV_PER_STAGE) + 5'(idx);
      d.evTime = timeStamp;
      d.evLevel = faultLevel;
      if (!idx[0]) begin
        d.logWr = 1'b1;
        d.logEntry = '{stamp: timeStamp,
                       code: 5'(STAGE * EV_PER_STAGE) + 5'(idx),
                       fault: faultType, preTrig: preTrigLevel,
                       faultLvl: faultLevel, preFault: preFaultLevel,
                       remain: q.remain, group: settingGroup};
      end
    end
    // a change arriving while its bit leaves is kept
    d.evPend = (q.evPend & ~clr) | newBits;

    if (q.logWr) begin
      d.logWp = (q.logWp == LOG_LAST) ? 4'h0 : q.logWp + 4'h1;
      d.logCnt = (q.logCnt == 4'(LOG_DEPTH)) ? q.logCnt
               : q.logCnt + 4'h1;
    end

    // zero wait states: the answer is prepared in the setup cycle
    d.pready = 1'b1;
    if (psel && !penable) begin
      d.pslverr = 1'b0;
      d.prdata = '0;
      unique case (paddr)
        REG_CTRL:   d.prdata = {22'h000000, q.evOffEn, q.evOnEn,
                                q.contMode, q.rstMode, q.relMode,
                                q.delayType};
        REG_DT:     d.prdata = 32'(q.dtDelay);
        REG_DIAL:   d.prdata = 32'(q.dialK);
        REG_EXP:    d.prdata = 32'(q.expo);
        REG_REL:    d.prdata = 32'(q.relDelay);
        REG_STAT:   d.prdata = {24'h000000, q.logCnt, q.pickup,
                                q.blocked, q.trip, q.start};
        REG_REMAIN: d.prdata = 32'(q.remain);
        REG_LOGSEL: d.prdata = 32'(q.logSel);
        REG_LOG0:   d.prdata = logWide[31:0];
        REG_LOG1:   d.prdata = logWide[63:32];
        REG_LOG2:   d.prdata = logWide[95:64];
        REG_LOG3:   d.prdata = logWide[127:96];
        default:    d.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && q.pready && !q.pslverr) begin
      unique case (paddr)
        REG_CTRL: begin
          d.delayType = pwdata[1:0];
          d.relMode = pwdata[3:2];
          d.rstMode = pwdata[5:4];
          d.contMode = pwdata[7:6];
          d.evOnEn = pwdata[8];
          d.evOffEn = pwdata[9];
        end
        REG_DT:     d.dtDelay = pwdata[17:0];
        REG_DIAL:   d.dialK = pwdata[12:0];
        REG_EXP:    d.expo = pwdata[11:0];
        REG_REL:    d.relDelay = pwdata[14:0];
        REG_LOGSEL: d.logSel = pwdata[3:0];
        default:    d.logSel = q.logSel;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign start = q.start;
  assign trip = q.trip;
  assign blocked = q.blocked;
  assign evValid = q.evValid;
  assign evCode = q.evCode;
  assign evTime = q.evTime;
  assign evLevel = q.evLevel;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence sStartLogged;
    q.logWr && q.logEntry.code == 5'(STAGE * EV_PER_STAGE);
  endsequence
  sequence sFreshPickup;
    tick && q.tmr == TM_IDLE && levelRatio > ONE_Q && !q.blkLvl;
  endsequence

  chk_instant_trip: assert property (
    sFreshPickup and (fixedMode && q.dtDelay == 18'h00000)
    |=> q.start && q.trip)
    else $error("instant stage did not trip with start");
  chk_fixed_delay: assert property (
    $rose(q.trip) && fixedMode |-> q.opCnt >= dtTicks)
    else $error("fixed delay trip came early");
  chk_release_hold: assert property (
    tick && q.tmr == TM_RUN && levelRatio < RELEASE_Q && !q.blkLvl
    && q.relMode == OPT_YES && relTicks > 16'h0001 |=> q.start)
    else $error("start not held during release");
  chk_release_fast: assert property (
    tick && q.tmr == TM_RUN && levelRatio < RELEASE_Q
    && q.relMode == OPT_NO |=> !q.start)
    else $error("start not dropped at pick-up loss");
  chk_counter_hold: assert property (
    tick && q.tmr == TM_REL && levelRatio < RELEASE_Q
    && q.contMode == OPT_NO && q.relCnt + 16'h0001 < relTicks
    |=> $stable(q.opCnt) && $stable(q.acc))
    else $error("operating counter moved during release");
  chk_block_start: assert property (
    tick && q.blkLvl |=> !q.start ##1 !q.start)
    else $error("start seen while blocked");
  chk_event_code: assert property (
    q.evValid |-> q.evCode >= 5'(STAGE * EV_PER_STAGE)
    && q.evCode < 5'(STAGE * EV_PER_STAGE + EV_PER_STAGE))
    else $error("event code outside stage range");
  chk_pickup_hyst: assert property (
    tick && q.pickup && levelRatio >= RELEASE_Q |=> q.pickup)
    else $error("pick-up released above 97 percent");
  chk_start_logged: assert property (
    $rose(q.start) |-> ##[0:6] sStartLogged)
    else $error("start on event missing from log");
endmodule : ott_trip_timer

// [tb/test_overlevel_trip_timer.sv]
// Purpose: self-checking bench for one over-level trip timer stage
// Assumes: ticks at least 64 clocks apart, APB answers without waits
// Notes:   stage 2 is used so that event codes carry a stage offset
`timescale 1ns/1ps
module test_overlevel_trip_timer;
  import ott_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic        e;
  } ott_row_type;

  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tick    = 1'b0;
  logic [15:0] levelRatio = 16'h0000;
  logic [15:0] faultLevel = 16'h0000;
  logic [31:0] timeStamp  = 32'h0;
  logic        blockIn    = 1'b0;
  logic        start;
  logic        trip;
  logic        blocked;
  logic        evValid;
  logic [4:0]  evCode;
  logic [31:0] evTime;
  logic [15:0] evLevel;
  logic [31:0] rdat;
  logic        rerr;
  logic [4:0]  evq[$];
  logic [31:0] lastTime;
  logic [15:0] lastLevel;
  int          failures = 0;
  int          compares = 0;
  int          n;
  int          qs;
  ott_row_type rows [8] = '{
    '{REG_CTRL, 32'h0000_0369, 1'b0},
    '{REG_DT, 32'h0000_0008, 1'b0},
    '{REG_DIAL, 32'h0000_0005, 1'b0},
    '{REG_EXP, 32'h0000_0064, 1'b0},
    '{REG_REL, 32'h0000_000C, 1'b0},
    '{REG_STAT, 32'h0000_0000, 1'b0},
    '{REG_REMAIN, 32'h0000_0000, 1'b0},
    '{8'h40, 32'h0000_0000, 1'b1}};

  ott_trip_timer #(.STAGE(2)) i_ott_trip_timer (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tick(tick),
    .levelRatio(levelRatio), .faultLevel(faultLevel),
    .preTrigLevel(16'h0123), .preFaultLevel(16'h0456),
    .faultType(3'h2), .settingGroup(3'h5), .timeStamp(timeStamp),
    .blockIn(blockIn), .start(start), .trip(trip), .blocked(blocked),
    .evValid(evValid), .evCode(evCode), .evTime(evTime),
    .evLevel(evLevel));

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (evValid === 1'b1) begin
      evq.push_back(evCode);
      lastTime  <= evTime;
      lastLevel <= evLevel;
    end
  end

  task chk(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // level is applied with the tick; long gap lets the power calc finish
  task step(input logic [15:0] r, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk_sys);
      levelRatio <= r;
      faultLevel <= r;
      tick       <= 1'b1;
      timeStamp  <= timeStamp + 32'h1;
      @(posedge clk_sys);
      tick <= 1'b0;
      repeat (62) @(posedge clk_sys);
    end
  endtask : step

  task outs(input string name, input logic [2:0] exp);
    chk(name, {29'h0, blocked, trip, start}, {29'h0, exp});
  endtask : outs

  task wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk("reg read", rdat, rows[i].d);
      chk("reg err", {31'h0, rerr}, {31'h0, rows[i].e});
    end
    outs("after reset", 3'b000);
    $display("done reset values");

    // fixed delay of 8 ticks counted from the start tick
    step(16'h0180, 1);
    outs("fixed start", 3'b001);
    step(16'h0180, 7);
    outs("fixed before", 3'b001);
    step(16'h0180, 1);
    outs("fixed trip", 3'b011);
    chk("ev start", {27'h0, evq[0]}, 32'd12);
    chk("ev trip", {27'h0, evq[1]}, 32'd14);
    chk("ev time", lastTime, 32'd9);
    chk("ev level", {16'h0, lastLevel}, 32'h0180);
    step(16'h0000, 1);
    outs("fixed drop", 3'b000);
    step(16'h0000, 13);
    $display("done fixed delay");

    // hysteresis keeps counting, release holds the count
    step(16'h0180, 4);
    step(16'h00FA, 2);
    apb(1'b0, REG_STAT, 32'h0);
    chk("hyst pickup", {28'h0, rdat[3:0]}, 32'h9);
    step(16'h00F0, 3);
    outs("hold start", 3'b001);
    step(16'h0180, 2);
    outs("hold no trip", 3'b001);
    step(16'h0180, 1);
    outs("hold trip", 3'b011);
    step(16'h0000, 14);
    $display("done release hold");

    // release delay of 12 ticks, then immediate release
    step(16'h0180, 1);
    step(16'h0000, 11);
    outs("rel held", 3'b001);
    step(16'h0000, 1);
    outs("rel end", 3'b000);
    apb(1'b1, REG_CTRL, 32'h0000_0265);
    qs = evq.size();
    step(16'h0180, 1);
    chk("on masked", evq.size(), qs);
    step(16'h0000, 1);
    outs("rel now", 3'b000);
    chk("off kept", evq.size(), qs + 1);
    step(16'h0000, 13);
    $display("done release modes");

    // zero delay trips with start
    apb(1'b1, REG_CTRL, 32'h0000_0369);
    apb(1'b1, REG_DT, 32'h0);
    step(16'h0180, 1);
    outs("instant", 3'b011);
    step(16'h0000, 14);
    apb(1'b1, REG_DT, 32'h8);
    $display("done instant");

    // pick-up while blocked, then blocking during start
    @(posedge clk_sys);
    blockIn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    step(16'h0180, 1);
    outs("blocked", 3'b100);
    chk("ev block", {27'h0, evq[evq.size()-1]}, 32'd16);
    @(posedge clk_sys);
    blockIn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    step(16'h0000, 1);
    step(16'h0180, 1);
    chk("unblk start", {31'h0, start}, 32'h1);
    @(posedge clk_sys);
    blockIn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    step(16'h0180, 1);
    chk("blk clears", {31'h0, start}, 32'h0);
    @(posedge clk_sys);
    blockIn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    step(16'h0000, 14);
    $display("done blocking");

    // ratio 2, exponent 1: one unit per tick, k of 50 ms is 10 ticks
    apb(1'b1, REG_CTRL, 32'h0000_036A);
    step(16'h0200, 1);
    n = 1;
    while (trip !== 1'b1 && n < 20) begin
      step(16'h0200, 1);
      n++;
    end
    chk("inv ticks", n, 32'd11);
    step(16'h0000, 14);
    $display("done inverse");

    // thirteen on events: log wrapped, slot 11 holds inverse start on
    apb(1'b0, REG_STAT, 32'h0);
    chk("log count", {24'h0, rdat[7:4], 4'h0}, 32'h0C0);
    apb(1'b1, REG_LOGSEL, 32'd11);
    apb(1'b0, REG_LOG2, 32'h0);
    chk("log code", {27'h0, rdat[13:9]}, 32'd12);
    apb(1'b0, REG_LOG0, 32'h0);
    chk("log group", {29'h0, rdat[2:0]}, 32'h5);
    $display("done log");

    // continue mode counts through release: trip at first re-pick-up
    apb(1'b1, REG_CTRL, 32'h0000_03A9);
    step(16'h0180, 4);
    step(16'h0000, 5);
    outs("cont no trip", 3'b001);
    step(16'h0180, 1);
    outs("cont trip", 3'b011);
    step(16'h0000, 14);
    // clear at loss: the count starts over at re-pick-up
    apb(1'b1, REG_CTRL, 32'h0000_0359);
    step(16'h0180, 4);
    step(16'h0000, 1);
    step(16'h0180, 7);
    outs("clr no trip", 3'b001);
    step(16'h0180, 1);
    outs("clr trip", 3'b011);
    step(16'h0000, 14);
    $display("done counter modes");

    // reset in mid-run clears outputs and restores counter hold in place of clear at loss
    step(16'h0180, 1);
    outs("pre reset", 3'b001);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    outs("in reset", 3'b000);
    resetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", rdat, 32'h0000_0369);
    $display("done mid reset");
    wrap_up();
  end
endmodule : test_overlevel_trip_timer
